//--- uefa_top.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "uefa_defines.svh"

module uefa_top #(
  parameter int NUM_EP = `UEFA_NUM_EP,
  parameter int DEPTH = `UEFA_FIFO_DEPTH,
  parameter int CNT_W = `UEFA_COUNT_LOW_W + `UEFA_COUNT_HIGH_W
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire uefa_pkg::uefa_rx_t i_rx,
  input wire uefa_pkg::uefa_ack_t i_in_ack,
  input wire uefa_pkg::uefa_tx_t i_tx,
  input wire logic [NUM_EP-1:0] i_ep_is_iso,
  output logic [7:0] o_tx_byte,
  output logic [NUM_EP-1:0] o_fifo_reset,
  output logic o_irq
);

  localparam int PW = $clog2(DEPTH);

  uefa_pkg::uefa_apb_st_t st_q;
  logic [`UEFA_SEL_W-1:0] sel_q;
  logic [NUM_EP-1:0] rst_q;
  logic [NUM_EP-1:0] mask_q;
  logic [NUM_EP-1:0] txc_q;
  logic [NUM_EP-1:0] txc_set;
  logic [PW-1:0] cpu_ptr_q [NUM_EP];
  logic [PW-1:0] sie_ptr_q [NUM_EP];
  logic [CNT_W-1:0] run_cnt_q [NUM_EP];
  logic [CNT_W-1:0] cnt_q [NUM_EP];
  logic [7:0] mem [NUM_EP][DEPTH];
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [7:0] tx_byte_q;

  logic [7:0] idx;
  logic aligned;
  logic hit_sel, hit_data, hit_rst, hit_low, hit_high, hit_flags, hit_stat, hit_mask;
  logic mapped, setup, done, wr;
  logic sel_ok, fifo_acc, rx_ok, tx_ok;
  logic [PW-1:0] cur_ptr;
  logic [7:0] cur_byte;
  logic [CNT_W-1:0] cur_cnt;

  assign idx = i_paddr[9:2];
  assign aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
  assign hit_sel = aligned && (idx == `UEFA_IDX_EP_SELECT);
  assign hit_data = aligned && (idx == `UEFA_IDX_FIFO_DATA);
  assign hit_rst = aligned && (idx == `UEFA_IDX_FIFO_RESET);
  assign hit_low = aligned && (idx == `UEFA_IDX_COUNT_LOW);
  assign hit_high = aligned && (idx == `UEFA_IDX_COUNT_HIGH);
  assign hit_flags = aligned && (idx == `UEFA_IDX_EP_INT_FLAGS);
  assign hit_stat = aligned && (idx == `UEFA_IDX_EP_STATUS);
  assign hit_mask = aligned && (idx == `UEFA_IDX_INT_MASK);
  assign mapped = hit_sel | hit_data | hit_rst | hit_low | hit_high | hit_flags | hit_stat
                | hit_mask;

  // no wait state: read data is fetched in setup so it leaves a flip-flop
  assign setup = i_psel & ~i_penable;
  assign done = i_psel & i_penable & o_pready;
  assign wr = done & i_pwrite;
  assign o_pready = (st_q == uefa_pkg::UEFA_ST_ANSWER);

  // select values above the last endpoint reach nothing and read zero
  assign sel_ok = (32'(sel_q) < NUM_EP);
  assign cur_ptr = sel_ok ? cpu_ptr_q[sel_q] : '0;
  // a fifo held in reset reads zero, like a select beyond the last endpoint
  assign cur_byte = (sel_ok && !rst_q[sel_q]) ? mem[sel_q][cur_ptr] : 8'h00;
  assign cur_cnt = sel_ok ? cnt_q[sel_q] : '0;
  // a fifo held in reset ignores the port until firmware releases it
  assign fifo_acc = done & hit_data & sel_ok & ~(sel_ok & rst_q[sel_q]);
  assign rx_ok = (32'(i_rx.ep) < NUM_EP) && !rst_q[i_rx.ep];
  assign tx_ok = i_tx.pop && (32'(i_tx.ep) < NUM_EP) && !rst_q[i_tx.ep];

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_q <= uefa_pkg::UEFA_ST_IDLE;
    end else begin
      case (st_q)
        uefa_pkg::UEFA_ST_IDLE: begin
          if (setup) begin
            st_q <= uefa_pkg::UEFA_ST_ANSWER;
          end
        end
        uefa_pkg::UEFA_ST_ANSWER: begin
          st_q <= uefa_pkg::UEFA_ST_IDLE;
        end
        default: begin
          st_q <= uefa_pkg::UEFA_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sel_q <= `UEFA_RST_SELECT;
      rst_q <= NUM_EP'(`UEFA_RST_FIFO_RESET);
      mask_q <= NUM_EP'(`UEFA_RST_INT_MASK);
    end else if (wr) begin
      if (hit_sel) begin
        sel_q <= i_pwdata[`UEFA_SEL_W-1:0];
      end
      if (hit_rst) begin
        rst_q <= i_pwdata[NUM_EP-1:0];
      end
      if (hit_mask) begin
        mask_q <= i_pwdata[NUM_EP-1:0];
      end
    end
  end
  assign o_fifo_reset = rst_q;

  // in-transfer-complete: a set in the cycle of a clearing write wins
  always_comb begin
    for (int e = 0; e < NUM_EP; e++) begin
      txc_set[e] = i_in_ack.ack && (32'(i_in_ack.ep) == e) && !i_ep_is_iso[e];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      txc_q <= '0;
    end else begin
      for (int e = 0; e < NUM_EP; e++) begin
        if (txc_set[e]) begin
          txc_q[e] <= 1'b1;
        end else if (wr && hit_stat && (32'(sel_q) == e) && i_pwdata[`UEFA_TXC_BIT]) begin
          txc_q[e] <= 1'b0;
        end
      end
    end
  end
  assign o_irq = |(txc_q & mask_q);

  always_ff @(posedge i_core_clk) begin
    for (int e = 0; e < NUM_EP; e++) begin
      if (i_srst || rst_q[e]) begin
        cpu_ptr_q[e] <= '0;
        sie_ptr_q[e] <= '0;
        run_cnt_q[e] <= '0;
        cnt_q[e] <= '0;
      end else if (txc_set[e]) begin
        cpu_ptr_q[e] <= '0;
        sie_ptr_q[e] <= '0;
      end else if (i_rx.done && (32'(i_rx.ep) == e)) begin
        cnt_q[e] <= run_cnt_q[e];
        run_cnt_q[e] <= '0;
        cpu_ptr_q[e] <= '0;
        sie_ptr_q[e] <= '0;
      end else begin
        if (fifo_acc && (32'(sel_q) == e)) begin
          cpu_ptr_q[e] <= cpu_ptr_q[e] + 1'b1;
        end
        if ((i_rx.valid && (32'(i_rx.ep) == e)) || (tx_ok && (32'(i_tx.ep) == e))) begin
          sie_ptr_q[e] <= sie_ptr_q[e] + 1'b1;
        end
        if (i_rx.valid && (32'(i_rx.ep) == e)) begin
          run_cnt_q[e] <= run_cnt_q[e] + 1'b1;
        end
      end
    end
  end

  // no reset on the array: its content is undefined until written
  always_ff @(posedge i_core_clk) begin
    if (wr && fifo_acc) begin
      mem[sel_q][cur_ptr] <= i_pwdata[7:0];
    end
    if (i_rx.valid && rx_ok) begin
      mem[i_rx.ep][sie_ptr_q[i_rx.ep]] <= i_rx.data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      tx_byte_q <= 8'h00;
    end else if (tx_ok) begin
      tx_byte_q <= mem[i_tx.ep][sie_ptr_q[i_tx.ep]];
    end
  end
  assign o_tx_byte = tx_byte_q;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= ~mapped;
      prdata_q <= 32'h0000_0000;
      if (!i_pwrite) begin
        if (hit_sel) begin
          prdata_q <= 32'(sel_q);
        end
        if (hit_data) begin
          prdata_q <= 32'(cur_byte);
        end
        if (hit_rst) begin
          prdata_q <= 32'(rst_q);
        end
        if (hit_low) begin
          prdata_q <= 32'(cur_cnt[7:0]);
        end
        if (hit_high) begin
          prdata_q <= 32'(cur_cnt >> 8);
        end
        if (hit_flags) begin
          prdata_q <= 32'(txc_q);
        end
        if (hit_stat) begin
          prdata_q <= 32'(sel_ok & txc_q[sel_q]);
        end
        if (hit_mask) begin
          prdata_q <= 32'(mask_q);
        end
      end
    end
  end
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  property p_txc_set;
    (|txc_set) |=> ((txc_q & $past(txc_set)) == $past(txc_set));
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("acked in packet did not set flag");

  property p_irq_raise;
    (|(txc_set & mask_q)) && !wr |=> o_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("enabled event raised no interrupt");

  property p_txc_sticky;
    !$past(i_srst) && (|($past(txc_q) & ~txc_q))
      |-> $past(wr && hit_stat && i_pwdata[`UEFA_TXC_BIT]);
  endproperty
  a_txc_sticky: assert property (p_txc_sticky) else $error("flag cleared without write");

  property p_ptr_step;
    fifo_acc && !i_rx.done && !i_in_ack.ack |=> cur_ptr == $past(cur_ptr) + 1'b1;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("fifo pointer did not advance");

  property p_data_read;
    setup && hit_data && !i_pwrite |=> o_pready && o_prdata == 32'($past(cur_byte));
  endproperty
  a_data_read: assert property (p_data_read) else $error("data port read wrong byte");

  property p_count_low;
    setup && hit_low && !i_pwrite |=> o_pready && o_prdata == 32'($past(cur_cnt[7:0]));
  endproperty
  a_count_low: assert property (p_count_low) else $error("count low mismatch");

  property p_count_high;
    o_pready && !i_pwrite && hit_high |-> o_prdata[31:`UEFA_COUNT_HIGH_W] == '0;
  endproperty
  a_count_high: assert property (p_count_high) else $error("reserved count bits not zero");

  property p_fifo_rst;
    sel_ok && rst_q[sel_q] && $stable(sel_q) && !(wr && hit_sel) |=> cur_ptr == '0 && cur_cnt == '0;
  endproperty
  a_fifo_rst: assert property (p_fifo_rst) else $error("fifo not held in reset");

  property p_flags_read;
    setup && hit_flags && !i_pwrite |=> o_prdata[NUM_EP-1:0] == $past(txc_q);
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag register mismatch");

  property p_flags_ro;
    wr && hit_flags |=> (txc_q & $past(txc_q)) == $past(txc_q);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("flag register changed by write");

  property p_rst_out;
    wr && hit_rst |=> o_fifo_reset == $past(i_pwdata[NUM_EP-1:0]);
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("fifo reset bits not written");

  property p_sel_far;
    setup && hit_data && !i_pwrite && !sel_ok |=> o_pready && o_prdata == 32'h0000_0000;
  endproperty
  a_sel_far: assert property (p_sel_far) else $error("unselectable endpoint read data");

endmodule

`default_nettype wire

//--- uefa_defines.svh
`ifndef UEFA_DEFINES_SVH
`define UEFA_DEFINES_SVH

// register indices; the byte address on the bus is four times the index
`define UEFA_IDX_EP_SELECT 8'hC7
`define UEFA_IDX_FIFO_DATA 8'hCF
`define UEFA_IDX_FIFO_RESET 8'hD5
`define UEFA_IDX_COUNT_LOW 8'hE2
`define UEFA_IDX_COUNT_HIGH 8'hE3
`define UEFA_IDX_EP_INT_FLAGS 8'hF8
`define UEFA_IDX_EP_STATUS 8'hC9
`define UEFA_IDX_INT_MASK 8'hCA

// field positions and widths
`define UEFA_TXC_BIT 0
`define UEFA_SEL_W 3
`define UEFA_COUNT_LOW_W 8
`define UEFA_COUNT_HIGH_W 3

// reset values
`define UEFA_RST_SELECT 3'h0
`define UEFA_RST_FIFO_RESET 8'h00
`define UEFA_RST_INT_MASK 8'h00

// sizes
`define UEFA_NUM_EP 6
`define UEFA_FIFO_DEPTH 64

`endif

//--- uefa_pkg.sv
`default_nettype none
package uefa_pkg;

  // one received byte, or end of an accepted out packet, from the serial engine
  typedef struct packed {
    logic valid;
    logic done;
    logic [2:0] ep;
    logic [7:0] data;
  } uefa_rx_t;

  // host acknowledged an in packet on endpoint ep
  typedef struct packed {
    logic ack;
    logic [2:0] ep;
  } uefa_ack_t;

  // serial engine takes the next in byte of endpoint ep
  typedef struct packed {
    logic pop;
    logic [2:0] ep;
  } uefa_tx_t;

  typedef enum logic [1:0] {
    UEFA_ST_IDLE = 2'b01,
    UEFA_ST_ANSWER = 2'b10
  } uefa_apb_st_t;

endpackage
`default_nettype wire

//--- uefa_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module uefa_host_model (
  input wire logic i_core_clk,
  output var uefa_pkg::uefa_rx_t o_rx,
  output var uefa_pkg::uefa_ack_t o_in_ack,
  output var uefa_pkg::uefa_tx_t o_tx
);
  initial begin
    o_rx = '0;
    o_in_ack = '0;
    o_tx = '0;
  end
  // out packet of n bytes then done; idle data inverted so a stale byte never matches
  task automatic send_out(input logic [2:0] ep, input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge i_core_clk);
      o_rx <= '{valid: 1'b1, done: 1'b0, ep: ep, data: base + 8'(i)};
    end
    @(posedge i_core_clk);
    o_rx <= '{valid: 1'b0, done: 1'b1, ep: ep, data: ~o_rx.data};
    @(posedge i_core_clk);
    o_rx.done <= 1'b0;
  endtask
  // host handshake on an in packet
  task automatic ack_in(input logic [2:0] ep);
    @(posedge i_core_clk);
    o_in_ack <= '{ack: 1'b1, ep: ep};
    @(posedge i_core_clk);
    o_in_ack.ack <= 1'b0;
  endtask
  task automatic pop(input logic [2:0] ep);
    @(posedge i_core_clk);
    o_tx <= '{pop: 1'b1, ep: ep};
    @(posedge i_core_clk);
    o_tx.pop <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test_usb_endpoint_fifo_access.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module test_usb_endpoint_fifo_access;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  logic [5:0] iso = '0;
  logic [5:0] frst;
  logic [7:0] txb;
  uefa_pkg::uefa_rx_t rx;
  uefa_pkg::uefa_ack_t ack;
  uefa_pkg::uefa_tx_t tx;
  int err_total = 0;
  int comparisons = 0;
  uefa_top DUT (.i_core_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_rx(rx), .i_in_ack(ack), .i_tx(tx),
    .i_ep_is_iso(iso), .o_tx_byte(txb), .o_fifo_reset(frst), .o_irq(irq));
  uefa_host_model host (.i_core_clk(clk), .o_rx(rx), .o_in_ack(ack), .o_tx(tx));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // one apb transfer; byte address is four times the register index
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(25ns * 40000);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    apb(1'b1, 8'hD5, 32'h3F);
    apb(1'b0, 8'hD5, 32'h0);
    `CHK("fifo_reset_reg", 32'h3F, rd)
    `CHK("fifo_reset_out", 6'h3F, frst)
    apb(1'b1, 8'hD5, 32'h0);
    host.send_out(3'd1, 3, 8'h50);
    host.send_out(3'd2, 300, 8'h00);
    apb(1'b1, 8'hC7, 32'h2);
    apb(1'b0, 8'hE2, 32'h0);
    `CHK("count_low_ep2", 32'h2C, rd)
    apb(1'b0, 8'hE3, 32'h0);
    `CHK("count_high_ep2", 32'h1, rd)
    apb(1'b1, 8'hC7, 32'h1);
    apb(1'b0, 8'hE2, 32'h0);
    `CHK("count_low_ep1", 32'h3, rd)
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'hCF, 32'h0);
      `CHK("fifo_byte", 32'(8'h50 + 8'(i)), rd)
    end
    apb(1'b1, 8'hC7, 32'h3);
    apb(1'b1, 8'hCF, 32'hA1);
    apb(1'b1, 8'hCF, 32'hA2);
    for (int i = 0; i < 2; i++) begin
      host.pop(3'd3);
      #1;
      `CHK("tx_byte", 8'hA1 + 8'(i), txb)
    end
    // isochronous acks must leave the flag alone
    @(posedge clk);
    iso <= 6'h10;
    host.ack_in(3'd3);
    host.ack_in(3'd4);
    apb(1'b0, 8'hF8, 32'h0);
    `CHK("ep_int_flags", 32'h08, rd)
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, 8'hCA, 32'h08);
    #1;
    `CHK("irq_enabled", 1'b1, irq)
    apb(1'b1, 8'hF8, 32'hFF);
    apb(1'b0, 8'hF8, 32'h0);
    `CHK("flags_read_only", 32'h08, rd)
    apb(1'b1, 8'hC9, 32'h1);
    apb(1'b0, 8'hF8, 32'h0);
    `CHK("flags_cleared", 32'h0, rd)
    #1;
    `CHK("irq_cleared", 1'b0, irq)
    // ack while already enabled: interrupt follows the set at once
    host.ack_in(3'd3);
    #1;
    `CHK("irq_on_ack", 1'b1, irq)
    apb(1'b0, 8'hC9, 32'h0);
    `CHK("ep_status", 32'h1, rd)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    apb(1'b1, 8'hC7, 32'h6);
    apb(1'b0, 8'hCF, 32'h0);
    `CHK("far_select_data", 32'h0, rd)
    report_and_stop();
  end
endmodule
`default_nettype wire
